// File: hdl/pid_isqrt.sv
// digit-by-digit integer square root, one root bit per clock
// assumes start is a one-cycle pulse; the radicand is taken at start
`timescale 1ns/100ps
module pid_isqrt #(
	parameter int RW = 48
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// request
	input wire logic start,
	input wire logic [RW-1:0] radicand,
	// answer
	output logic done,
	output logic [RW/2-1:0] root
);
	localparam int HW = RW / 2;
	localparam int CW = $clog2(HW + 1);

	typedef struct packed {
		logic busy;
		logic [CW-1:0] cnt;
		logic [RW-1:0] rad;
		logic [HW+1:0] rem;
		logic [HW-1:0] root;
		logic done;
	} sqrt_t;

	sqrt_t s_ff, nxt_s;

	initial
	begin
		if (RW % 2 != 0 || RW < 4)
			$error("radicand width must be even and at least 4");
	end

	// two radicand bits enter per cycle, the trial divisor decides one root bit
	always_comb
	begin
		logic [HW+1:0] r2;
		logic [HW+1:0] trial;
		r2 = '0;
		trial = '0;
		nxt_s = s_ff;
		nxt_s.done = 1'b0;
		if (start)
		begin
			nxt_s.busy = 1'b1;
			nxt_s.cnt = CW'(HW);
			nxt_s.rad = radicand;
			nxt_s.rem = '0;
			nxt_s.root = '0;
		end
		else if (s_ff.busy)
		begin
			r2 = {s_ff.rem[HW-1:0], s_ff.rad[RW-1:RW-2]};
			trial = {s_ff.root, 2'b01};
			if (r2 >= trial)
			begin
				nxt_s.rem = r2 - trial;
				nxt_s.root = {s_ff.root[HW-2:0], 1'b1};
			end
			else
			begin
				nxt_s.rem = r2;
				nxt_s.root = {s_ff.root[HW-2:0], 1'b0};
			end
			nxt_s.rad = {s_ff.rad[RW-3:0], 2'b00};
			nxt_s.cnt = s_ff.cnt - 1'b1;
			if (s_ff.cnt == CW'(1))
			begin
				nxt_s.busy = 1'b0;
				nxt_s.done = 1'b1;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			s_ff <= '0;
		else
			s_ff <= nxt_s;
	end

	assign done = s_ff.done;
	assign root = s_ff.root;
endmodule

// File: hdl/pid_loop_controller.sv
// sampled pid loop calculator with alarms, register port and mode handling
// assumes a synchronous register master and a process value from a pin
// Notes on behaviour
// R1: step bias scaling rescales bias by new/old setpoint, inverted when reverse acting
// R2: scaled bias is clamped to the range zero to one
// R3: integral period 9999 stops integration; bias stays software adjustable
// R4: derivative period zero removes derivative action
// R5: integral and derivative coefficients from gain and periods; zero gain drops gain factor
// R6: velocity form outputs change: gain error step, integral, minus second difference
// R7: manual to automatic sets setpoint to process value and bias to output
// R8: two transfer types chosen by a setup bit
// R9: four limit alarms: high-high, high above limits, low, low-low below
// R10: yellow and optional orange deviation alarms on distance from setpoint
// R11: rate alarm when process value moves more than rate limit per sample
// R12: limit and deviation alarms set past threshold with hysteresis band
// R13: manual mode takes operator output; alarms still evaluated every sample
// R14: automatic mode computes output from stored settings and evaluates alarms
// R15: cascade acts as automatic with setpoint from another loop output
// R16: reverse action negates integral and proportional, flips derivative sign
// R17: square root option replaces process value before error and alarms
// R18: error squared keeps sign: difference times its absolute value
// R19: deadband zeroes error inside symmetric band around setpoint
// R20: with both options the error is squared before the deadband test
// R21: derivative gain limiting filters the derivative input with first order lag
// R22: position output clamped to zero to one
// R23: freeze bias holds bias while unclamped output is out of range
// R24: otherwise saturation recomputes bias as clamped output minus p and d terms
// R25: position derivative acts on process value change, not error change
// R26: active limit or deviation alarm clears only after returning past threshold by hysteresis; rate alarm has no hysteresis
// R27: loop state updates once per sample and resets to zero
`timescale 1ns/100ps
module pid_loop_controller #(
	parameter int SAMPLE_CYCLES_RST = pid_pkg::SAMPLE_CYCLES
) (
	// clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// register port
	input wire logic [4:0] addr,
	input wire logic [31:0] wr_data,
	input wire logic wr_en,
	input wire logic rd_en,
	output logic [31:0] rd_data,
	// process side
	input wire logic [31:0] process_value,
	input wire logic [31:0] cascade_setpoint,
	output logic [31:0] control_out,
	output logic [pid_pkg::NALM-1:0] alarm_flags,
	output logic sample_done
);
	typedef struct packed {
		pid_pkg::state_t st;
		logic [pid_pkg::NCFG-1:0][31:0] cfg;
		logic [31:0] smp_cnt;
		logic [31:0] pv_meta;
		logic [31:0] pv_sync;
		logic [31:0] pv_cap;
		logic [31:0] pv_last;
		logic [31:0] x1;
		logic [31:0] x2;
		logic [31:0] yf;
		logic [31:0] e1;
		logic [31:0] bias_term;
		logic [31:0] out;
		logic [31:0] ki;
		logic [31:0] kr;
		logic [31:0] tmp;
		logic [31:0] fc;
		logic [31:0] sp_prev;
		logic [1:0] mode_prev;
		logic [pid_pkg::NALM-1:0] alm;
		logic [31:0] rd;
		logic div_go;
		logic sq_go;
		logic dneg;
		logic done;
	} core_t;

	core_t s_ff, nxt_s;
	logic [1:0] rst_sync_ff;
	logic rst_n;
	logic div_done, sq_done;
	logic [31:0] div_q;
	logic [23:0] sq_root;
	logic signed [31:0] div_a, div_b;

	initial
	begin
		if (SAMPLE_CYCLES_RST < 2)
			$error("sample period must be at least two cycles");
	end

	// reset released through two flops so every flop leaves reset on one edge
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			rst_sync_ff <= 2'b00;
		else
			rst_sync_ff <= {rst_sync_ff[0], 1'b1};
	end
	assign rst_n = rst_sync_ff[1];

	function automatic logic signed [31:0] qmul(input logic signed [31:0] a,
		input logic signed [31:0] b);
		logic signed [63:0] p;
		p = a * b;
		return p[47:16];
	endfunction

	function automatic logic signed [31:0] qabs(input logic signed [31:0] a);
		return (a < 0) ? -a : a;
	endfunction

	function automatic logic signed [31:0] clamp01(input logic signed [31:0] a);
		if (a < 0)
			return 32'sh0;
		else if (a > pid_pkg::Q_ONE)
			return pid_pkg::Q_ONE;
		return a;
	endfunction

	// alarm above a limit; once active it needs a drop below limit minus hysteresis
	function automatic logic alarm_hi(input logic act, input logic signed [31:0] v,
		input logic signed [31:0] lim, input logic signed [31:0] h);
		return act ? !(v < lim - h) : (v > lim);
	endfunction

	function automatic logic alarm_lo(input logic act, input logic signed [31:0] v,
		input logic signed [31:0] lim, input logic signed [31:0] h);
		return act ? !(v > lim + h) : (v < lim);
	endfunction

	// short names for settings
	logic [31:0] ctrl;
	logic [1:0] mode;
	logic is_manual, vel, rev, xfer, step_ok;
	logic signed [31:0] gain, ts, td, sp_eff, x, sq_ext;
	assign ctrl = s_ff.cfg[pid_pkg::REG_CTRL];
	assign mode = ctrl[pid_pkg::F_MODE +: 2];
	assign is_manual = (mode == pid_pkg::MODE_MANUAL);
	assign vel = ctrl[pid_pkg::F_VEL];
	assign rev = ctrl[pid_pkg::F_REV];
	assign gain = s_ff.cfg[pid_pkg::REG_GAIN];
	assign ts = s_ff.cfg[pid_pkg::REG_SAMPLE_INTERVAL];
	assign td = s_ff.cfg[pid_pkg::REG_DER_PERIOD];
	assign sq_ext = {8'h00, sq_root};
	assign x = ctrl[pid_pkg::F_SQRT] ? sq_ext : s_ff.pv_cap; // see R17
	assign xfer = (s_ff.mode_prev == pid_pkg::MODE_MANUAL) && !is_manual && !vel; // see R7
	// cascade takes the other loop's output as setpoint; see R15
	assign sp_eff = (xfer && !ctrl[pid_pkg::F_XFER2]) ? x :
		(mode == pid_pkg::MODE_CASCADE) ? cascade_setpoint : s_ff.cfg[pid_pkg::REG_SETPOINT];
	// bias scaling only with the adjusting-bias action and a real setpoint step; see R1
	assign step_ok = ctrl[pid_pkg::F_STEP] && !ctrl[pid_pkg::F_FREEZE] && !vel && !is_manual
		&& !xfer && sp_eff != s_ff.sp_prev && s_ff.sp_prev != '0 && sp_eff != '0;

	// operands of the shared divider, chosen by the sequencing state
	always_comb
	begin
		div_a = '0;
		div_b = '0;
		case (s_ff.st)
			pid_pkg::ST_KI:
			begin
				div_a = (gain != 0) ? qmul(gain, ts) : ts; // see R5
				div_b = s_ff.cfg[pid_pkg::REG_INT_PERIOD];
			end
			pid_pkg::ST_KR:
			begin
				div_a = (gain != 0) ? qmul(gain, td) : td; // see R5
				div_b = ts;
			end
			pid_pkg::ST_FA:
			begin
				div_a = td;
				div_b = s_ff.cfg[pid_pkg::REG_RATE_FILTER];
			end
			pid_pkg::ST_FB:
			begin
				div_a = ts;
				div_b = ts + s_ff.tmp; // see R21
			end
			pid_pkg::ST_STEP:
			begin
				div_a = qmul(s_ff.bias_term, rev ? s_ff.sp_prev : sp_eff); // see R1
				div_b = rev ? sp_eff : s_ff.sp_prev;
			end
			default:
			begin
				div_a = '0;
				div_b = '0;
			end
		endcase
	end

	pid_udiv #(.NW(48), .DW(32)) u_div (
		.clk(clk),
		.rst_n(rst_n),
		.start(s_ff.div_go),
		.dividend({qabs(div_a), 16'h0000}),
		.divisor(qabs(div_b)),
		.done(div_done),
		.quotient(div_q)
	);

	pid_isqrt #(.RW(48)) u_sqrt (
		.clk(clk),
		.rst_n(rst_n),
		.start(s_ff.sq_go),
		.radicand({s_ff.pv_cap[31] ? 32'h0 : s_ff.pv_cap, 16'h0000}),
		.done(sq_done),
		.root(sq_root)
	);

	// loop arithmetic of the commit cycle
	logic signed [31:0] e0, esq, e, ki_eff, kr_eff, dres, dx, d1, d2;
	logic signed [31:0] pterm, iterm, pd, bias_base, bias_new, m, mc, dm, dev;
	always_comb
	begin
		dres = s_ff.dneg ? -$signed(div_q) : $signed(div_q);
		e0 = sp_eff - x;
		esq = ctrl[pid_pkg::F_ESQ] ? qmul(e0, qabs(e0)) : e0; // see R18
		// squared first, deadband after; see R20
		e = (ctrl[pid_pkg::F_EDB] && qabs(esq) < $signed(s_ff.cfg[pid_pkg::REG_DEADBAND])) ?
			32'sh0 : esq; // see R19
		ki_eff = (s_ff.cfg[pid_pkg::REG_INT_PERIOD] == pid_pkg::TI_DISABLE) ? 32'sh0 : s_ff.ki;
		kr_eff = (td == 0) ? 32'sh0 : s_ff.kr; // see R4
		// filtered derivative input when limiting is on and the coefficient is usable
		dx = (ctrl[pid_pkg::F_DLIM] && s_ff.cfg[pid_pkg::REG_RATE_FILTER] != '0) ?
			s_ff.yf + qmul(s_ff.fc, x - s_ff.yf) : x; // see R21
		d1 = dx - s_ff.x1; // see R25
		d2 = dx - (s_ff.x1 <<< 1) + s_ff.x2;
		pterm = qmul(gain, e);
		iterm = qmul(ki_eff, e);
		bias_base = xfer ? s_ff.out : step_ok ? clamp01(dres) : s_ff.bias_term; // see R2
		// reverse action flips every error contribution; see R16
		bias_new = rev ? bias_base - iterm : bias_base + iterm; // see R3
		pd = rev ? qmul(kr_eff, d1) - pterm : pterm - qmul(kr_eff, d1);
		m = pd + bias_new;
		mc = clamp01(m); // see R22
		dm = qmul(gain, e - s_ff.e1) + iterm - qmul(kr_eff, d2); // see R6
		if (rev)
			dm = -dm;
		dev = qabs(x - sp_eff);
	end

	// register port, sample timer, sequencing and commit
	always_comb
	begin
		logic [31:0] hyst;
		hyst = s_ff.cfg[pid_pkg::REG_HYST];
		nxt_s = s_ff;
		nxt_s.div_go = 1'b0;
		nxt_s.sq_go = 1'b0;
		nxt_s.done = 1'b0;
		nxt_s.pv_meta = process_value;
		nxt_s.pv_sync = s_ff.pv_meta;
		if (s_ff.div_go)
			nxt_s.dneg = div_a[31] ^ div_b[31];
		if (wr_en && addr < 5'(pid_pkg::NCFG))
			nxt_s.cfg[addr] = wr_data;
		if (wr_en && addr == pid_pkg::REG_BIAS)
			nxt_s.bias_term = wr_data;
		if (rd_en)
		begin
			if (addr == pid_pkg::REG_BIAS)
				nxt_s.rd = s_ff.bias_term;
			else if (addr < 5'(pid_pkg::NCFG))
				nxt_s.rd = s_ff.cfg[addr];
			else if (addr == pid_pkg::REG_OUTPUT)
				nxt_s.rd = s_ff.out;
			else if (addr == pid_pkg::REG_STATUS)
				nxt_s.rd = {22'h0, (s_ff.st != pid_pkg::ST_IDLE), s_ff.alm, mode};
			else if (addr == pid_pkg::REG_PV)
				nxt_s.rd = x;
			else
				nxt_s.rd = 32'h0000_0000;
		end
		// sample timer; a tick during a busy sequence is dropped
		if (s_ff.smp_cnt <= 32'h0000_0001)
			nxt_s.smp_cnt = (s_ff.cfg[pid_pkg::REG_PERIOD] == '0) ? 32'h0000_0001 :
				s_ff.cfg[pid_pkg::REG_PERIOD];
		else
			nxt_s.smp_cnt = s_ff.smp_cnt - 1'b1;
		case (s_ff.st)
			pid_pkg::ST_IDLE:
				if (s_ff.smp_cnt <= 32'h0000_0001)
				begin
					nxt_s.pv_cap = s_ff.pv_sync;
					nxt_s.st = pid_pkg::ST_SQRT;
					nxt_s.sq_go = 1'b1;
				end
			pid_pkg::ST_SQRT:
				if (sq_done)
				begin
					nxt_s.st = pid_pkg::ST_KI;
					nxt_s.div_go = 1'b1;
				end
			pid_pkg::ST_KI:
				if (div_done)
				begin
					nxt_s.ki = dres;
					nxt_s.st = pid_pkg::ST_KR;
					nxt_s.div_go = 1'b1;
				end
			pid_pkg::ST_KR:
				if (div_done)
				begin
					nxt_s.kr = dres;
					nxt_s.st = pid_pkg::ST_FA;
					nxt_s.div_go = 1'b1;
				end
			pid_pkg::ST_FA:
				if (div_done)
				begin
					nxt_s.tmp = dres;
					nxt_s.st = pid_pkg::ST_FB;
					nxt_s.div_go = 1'b1;
				end
			pid_pkg::ST_FB:
				if (div_done)
				begin
					nxt_s.fc = dres;
					nxt_s.st = pid_pkg::ST_STEP;
					nxt_s.div_go = 1'b1;
				end
			pid_pkg::ST_STEP:
				if (div_done)
				begin
					nxt_s.tmp = dres;
					nxt_s.st = pid_pkg::ST_CALC;
				end
			pid_pkg::ST_CALC:
			begin
				// alarms run in every mode; see R13 R14
				nxt_s.alm[pid_pkg::A_HH] = alarm_hi(s_ff.alm[pid_pkg::A_HH], x,
					s_ff.cfg[pid_pkg::REG_LIM_HH], hyst); // see R9 R12 R26
				nxt_s.alm[pid_pkg::A_H] = alarm_hi(s_ff.alm[pid_pkg::A_H], x,
					s_ff.cfg[pid_pkg::REG_LIM_H], hyst); // see R9
				nxt_s.alm[pid_pkg::A_L] = alarm_lo(s_ff.alm[pid_pkg::A_L], x,
					s_ff.cfg[pid_pkg::REG_LIM_L], hyst); // see R9
				nxt_s.alm[pid_pkg::A_LL] = alarm_lo(s_ff.alm[pid_pkg::A_LL], x,
					s_ff.cfg[pid_pkg::REG_LIM_LL], hyst); // see R9 R26
				nxt_s.alm[pid_pkg::A_YEL] = alarm_hi(s_ff.alm[pid_pkg::A_YEL], dev,
					s_ff.cfg[pid_pkg::REG_DEV_YELLOW], hyst); // see R10 R12
				nxt_s.alm[pid_pkg::A_ORG] = alarm_hi(s_ff.alm[pid_pkg::A_ORG], dev,
					s_ff.cfg[pid_pkg::REG_DEV_ORANGE], hyst); // see R10
				nxt_s.alm[pid_pkg::A_RATE] = qabs(x - s_ff.pv_last) >
					$signed(s_ff.cfg[pid_pkg::REG_RATE_LIM]); // see R11
				nxt_s.alm = nxt_s.alm & ctrl[pid_pkg::F_ALEN +: pid_pkg::NALM];
				if (is_manual)
					nxt_s.out = s_ff.cfg[pid_pkg::REG_MANUAL_OUT]; // see R13
				else if (vel)
				begin
					nxt_s.out = dm; // see R6 R14
					nxt_s.bias_term = bias_new;
				end
				else
				begin
					nxt_s.out = mc; // see R14 R22
					if (m == mc)
						nxt_s.bias_term = bias_new;
					else if (ctrl[pid_pkg::F_FREEZE])
						nxt_s.bias_term = bias_base; // see R23
					else
						nxt_s.bias_term = mc - pd; // see R24
				end
				// both transfer types load the bias; only the first moves the setpoint
				if (xfer && !ctrl[pid_pkg::F_XFER2])
					nxt_s.cfg[pid_pkg::REG_SETPOINT] = x; // see R7 R8
				// history advances once per sample; see R27
				nxt_s.pv_last = x;
				nxt_s.x2 = s_ff.x1;
				nxt_s.x1 = dx;
				nxt_s.yf = dx;
				nxt_s.e1 = e;
				nxt_s.sp_prev = sp_eff;
				nxt_s.mode_prev = mode;
				nxt_s.done = 1'b1;
				nxt_s.st = pid_pkg::ST_IDLE;
			end
			default:
				nxt_s.st = pid_pkg::ST_IDLE;
		endcase
	end

	// loop state clears on reset; sample timer and preset settings load reset values; see R27
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			s_ff <= '0;
			s_ff.st <= pid_pkg::ST_IDLE;
			s_ff.smp_cnt <= 32'(SAMPLE_CYCLES_RST);
			s_ff.cfg[pid_pkg::REG_CTRL] <= pid_pkg::CTRL_RST;
			s_ff.cfg[pid_pkg::REG_GAIN] <= pid_pkg::GAIN_RST;
			s_ff.cfg[pid_pkg::REG_INT_PERIOD] <= pid_pkg::INT_PERIOD_RST;
			s_ff.cfg[pid_pkg::REG_SAMPLE_INTERVAL] <= pid_pkg::TS_RST;
			s_ff.cfg[pid_pkg::REG_PERIOD] <= 32'(SAMPLE_CYCLES_RST);
		end
		else
			s_ff <= nxt_s;
	end

	assign rd_data = s_ff.rd;
	assign control_out = s_ff.out;
	assign alarm_flags = s_ff.alm;
	assign sample_done = s_ff.done;
endmodule

// File: hdl/pid_udiv.sv
// unsigned restoring divider, one quotient bit per clock
// assumes start is a one-cycle pulse and operands are held only at start
`timescale 1ns/100ps
module pid_udiv #(
	parameter int NW = 48,
	parameter int DW = 32
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// request
	input wire logic start,
	input wire logic [NW-1:0] dividend,
	input wire logic [DW-1:0] divisor,
	// answer
	output logic done,
	output logic [DW-1:0] quotient
);
	localparam int CW = $clog2(NW + 1);

	typedef struct packed {
		logic busy;
		logic [CW-1:0] cnt;
		logic [DW:0] rem;
		logic [NW-1:0] quo;
		logic [DW-1:0] den;
		logic done;
		logic [DW-1:0] q;
	} div_t;

	div_t s_ff, nxt_s;

	initial
	begin
		if (NW <= DW)
			$error("dividend must be wider than divisor");
	end

	// one subtract-and-shift per cycle; overflow or zero divisor saturates positive
	always_comb
	begin
		logic [DW:0] sh;
		logic bitv;
		sh = '0;
		bitv = 1'b0;
		nxt_s = s_ff;
		nxt_s.done = 1'b0;
		if (start)
		begin
			nxt_s.busy = 1'b1;
			nxt_s.cnt = CW'(NW);
			nxt_s.rem = '0;
			nxt_s.quo = dividend;
			nxt_s.den = divisor;
		end
		else if (s_ff.busy)
		begin
			sh = {s_ff.rem[DW-1:0], s_ff.quo[NW-1]};
			bitv = (sh >= {1'b0, s_ff.den});
			nxt_s.rem = bitv ? sh - {1'b0, s_ff.den} : sh;
			nxt_s.quo = {s_ff.quo[NW-2:0], bitv};
			nxt_s.cnt = s_ff.cnt - 1'b1;
			if (s_ff.cnt == CW'(1))
			begin
				nxt_s.busy = 1'b0;
				nxt_s.done = 1'b1;
				nxt_s.q = (s_ff.den == '0 || (|nxt_s.quo[NW-1:DW-1])) ?
					{1'b0, {(DW-1){1'b1}}} : nxt_s.quo[DW-1:0];
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			s_ff <= '0;
		else
			s_ff <= nxt_s;
	end

	assign done = s_ff.done;
	assign quotient = s_ff.q;
endmodule

// File: shared/pid_pkg.sv
// constants, register map and state encoding of the sampled loop calculator
// assumes signed q16.16 fixed point for every normalized value and time
package pid_pkg;

	// fixed point
	localparam int DATA_W = 32;
	localparam int FRAC_W = 16;
	localparam logic signed [31:0] Q_ONE = 32'sh0001_0000;
	localparam logic [31:0] TI_DISABLE = 32'h270f_0000; // 9999.0 switches integral off

	// timing
	localparam int CLK_PERIOD_PS = 5000;
	localparam int SAMPLE_TIME_NS = 100000;
	localparam int SAMPLE_CYCLES = (SAMPLE_TIME_NS * 1000) / CLK_PERIOD_PS;

	// register word indices
	localparam logic [4:0] REG_CTRL = 5'h00;
	localparam logic [4:0] REG_SETPOINT = 5'h01;
	localparam logic [4:0] REG_GAIN = 5'h02;
	localparam logic [4:0] REG_INT_PERIOD = 5'h03;
	localparam logic [4:0] REG_DER_PERIOD = 5'h04;
	localparam logic [4:0] REG_SAMPLE_INTERVAL = 5'h05;
	localparam logic [4:0] REG_RATE_FILTER = 5'h06;
	localparam logic [4:0] REG_PERIOD = 5'h07;
	localparam logic [4:0] REG_MANUAL_OUT = 5'h08;
	localparam logic [4:0] REG_BIAS = 5'h09;
	localparam logic [4:0] REG_LIM_HH = 5'h0a;
	localparam logic [4:0] REG_LIM_H = 5'h0b;
	localparam logic [4:0] REG_LIM_L = 5'h0c;
	localparam logic [4:0] REG_LIM_LL = 5'h0d;
	localparam logic [4:0] REG_DEV_YELLOW = 5'h0e;
	localparam logic [4:0] REG_DEV_ORANGE = 5'h0f;
	localparam logic [4:0] REG_RATE_LIM = 5'h10;
	localparam logic [4:0] REG_HYST = 5'h11;
	localparam logic [4:0] REG_DEADBAND = 5'h12;
	localparam logic [4:0] REG_OUTPUT = 5'h13;
	localparam logic [4:0] REG_STATUS = 5'h14;
	localparam logic [4:0] REG_PV = 5'h15;
	localparam int NCFG = 19;

	// control register fields
	localparam int F_MODE = 0;
	localparam int F_VEL = 2;
	localparam int F_REV = 3;
	localparam int F_STEP = 4;
	localparam int F_FREEZE = 5;
	localparam int F_SQRT = 6;
	localparam int F_ESQ = 7;
	localparam int F_EDB = 8;
	localparam int F_DLIM = 9;
	localparam int F_XFER2 = 10;
	localparam int F_ALEN = 11;

	// alarm bit positions
	localparam int A_HH = 0;
	localparam int A_H = 1;
	localparam int A_L = 2;
	localparam int A_LL = 3;
	localparam int A_YEL = 4;
	localparam int A_ORG = 5;
	localparam int A_RATE = 6;
	localparam int NALM = 7;

	// loop modes
	localparam logic [1:0] MODE_MANUAL = 2'h0;
	localparam logic [1:0] MODE_AUTO = 2'h1;
	localparam logic [1:0] MODE_CASCADE = 2'h2;

	// reset values
	localparam logic [31:0] CTRL_RST = 32'h0000_0000;
	localparam logic [31:0] GAIN_RST = 32'h0001_0000;
	localparam logic [31:0] INT_PERIOD_RST = TI_DISABLE;
	localparam logic [31:0] TS_RST = 32'h0000_199a;

	typedef enum logic [2:0] {ST_IDLE, ST_SQRT, ST_KI, ST_KR, ST_FA, ST_FB, ST_STEP, ST_CALC} state_t;

endpackage

// File: test/pid_loop_controller_checker.sv
// port assertions for the sampled loop calculator
// assumes mode and manual words are written only between samples
`timescale 1ns/100ps
module pid_loop_controller_checker (
	// clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// register port
	input wire logic [4:0] addr,
	input wire logic [31:0] wr_data,
	input wire logic wr_en,
	input wire logic rd_en,
	input wire logic [31:0] rd_data,
	// process side
	input wire logic [31:0] control_out,
	input wire logic [pid_pkg::NALM-1:0] alarm_flags,
	input wire logic sample_done
);
	logic [31:0] ctrl_ff;
	logic [31:0] man_ff;
	logic manual;
	// shadows of mode word and manual output
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			ctrl_ff <= 32'h0;
			man_ff <= 32'h0;
		end
		else if (wr_en && addr == pid_pkg::REG_CTRL)
			ctrl_ff <= wr_data;
		else if (wr_en && addr == pid_pkg::REG_MANUAL_OUT)
			man_ff <= wr_data;
	end
	assign manual = ctrl_ff[1:0] == pid_pkg::MODE_MANUAL;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!arst_n);
	// a commit is a lone pulse; control and alarm outputs move only with it
	done_pulse_a: assert property (sample_done |=> !sample_done [*8])
		else $error("sample_done not a lone pulse");
	out_hold_a: assert property (!$stable(control_out) |-> sample_done)
		else $error("control_out moved off commit");
	alarm_hold_a: assert property (!$stable(alarm_flags) |-> sample_done)
		else $error("alarm_flags moved off commit");
	// position output stays normalized
	clamp_out_a: assert property (sample_done && !manual && !ctrl_ff[2] |->
		!control_out[31] && $signed(control_out) <= pid_pkg::Q_ONE)
		else $error("position output out of range");
	manual_out_a: assert property (sample_done && manual |-> control_out == man_ff)
		else $error("manual word not passed");
	alarm_mask_a: assert property (sample_done |-> (alarm_flags & ~ctrl_ff[17:11]) == 7'h0)
		else $error("disabled alarm raised");
	// read-only words mirror the outputs
	status_read_a: assert property (rd_en && addr == pid_pkg::REG_STATUS |=>
		rd_data[8:2] == $past(alarm_flags))
		else $error("status word mismatch");
	output_read_a: assert property (rd_en && addr == pid_pkg::REG_OUTPUT |=>
		rd_data == $past(control_out))
		else $error("output word mismatch");
	auto_c: cover property (sample_done && ctrl_ff[1:0] == pid_pkg::MODE_AUTO);
	casc_c: cover property (sample_done && ctrl_ff[1:0] == pid_pkg::MODE_CASCADE);
	rate_c: cover property (sample_done && alarm_flags[pid_pkg::A_RATE]);
endmodule

bind pid_loop_controller pid_loop_controller_checker chk_u (
	.clk(clk), .arst_n(arst_n), .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en),
	.rd_data(rd_data), .control_out(control_out), .alarm_flags(alarm_flags),
	.sample_done(sample_done));

// File: test/pid_plant_model.sv
// sensor and upstream loop channels facing the calculator
// assumes the bench names the wanted readings
`timescale 1ns/100ps
module pid_plant_model (
	// clock
	input wire logic clk,
	// bench side
	input wire logic [31:0] pv_req,
	input wire logic [31:0] cas_req,
	// loop side
	output logic [31:0] process_value = 32'h0,
	output logic [31:0] cascade_setpoint = 32'h0
);
	// sensor lags a clock, updating on the capture edge
	always @(posedge clk)
	begin
		process_value <= pv_req;
		cascade_setpoint <= cas_req;
	end
endmodule

// File: test/tb_pid_loop_controller.sv
// self-checking bench of the loop calculator
// assumes the plant model and a 400-clock sample period
`timescale 1ns/100ps
module tb_pid_loop_controller;
	logic clk = 1'b0;
	logic arst_n = 1'b0;
	logic [4:0] addr = 5'h00;
	logic [31:0] wr_data = 32'h0;
	logic wr_en = 1'b0;
	logic rd_en = 1'b0;
	logic [31:0] pv_req = 32'h0;
	logic [31:0] cas_req = 32'h0;
	logic [31:0] rd_data, process_value, cascade_setpoint, control_out, c;
	logic [6:0] alarm_flags;
	logic sample_done;
	logic signed [31:0] lm [8] = '{'he666, 'h999a, 'h4ccd, 'h199a, 'h3333, 'h6666, 'h8000, 'hccd};
	logic signed [31:0] pt [8] = '{'h8000, 'ha666, 'h947b, 'h851f, 'hf333, 'h3333, 'hccd, 'h1eb8};
	logic [6:0] ft [8] = '{7'h00, 7'h02, 7'h02, 7'h00, 7'h33, 7'h54, 7'h3c, 7'h3c};
	logic signed [31:0] et [6] = '{'h8000, -'sh8000, 'h4000, 'h6666, 'h8000, 'ha000};
	logic signed [31:0] s, v, g, b;
	int failures = 0;
	int checks_done = 0;
	int seed = 32'h4b6d;
	int i;
	always #2.5 clk = ~clk;
	pid_loop_controller #(.SAMPLE_CYCLES_RST(400)) dut_u (.clk(clk), .arst_n(arst_n),
		.addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
		.process_value(process_value), .cascade_setpoint(cascade_setpoint),
		.control_out(control_out), .alarm_flags(alarm_flags), .sample_done(sample_done));
	pid_plant_model plant_u (.clk(clk), .pv_req(pv_req), .cas_req(cas_req),
		.process_value(process_value), .cascade_setpoint(cascade_setpoint));
	// expectation helpers in q16.16
	function automatic logic signed [31:0] mulq(input logic signed [31:0] x, y);
		logic signed [63:0] t;
		t = x * y;
		return t[47:16];
	endfunction
	function automatic logic signed [31:0] clampq(input logic signed [31:0] x);
		return x < 0 ? 32'sh0 : (x > 32'sh10000 ? 32'sh10000 : x);
	endfunction
	function automatic logic signed [31:0] errq(input logic signed [31:0] d, input logic [31:0] m);
		logic signed [31:0] q;
		q = m[7] ? mulq(d, d < 0 ? -d : d) : d;
		return m[8] && (q < 0 ? -q : q) < 32'sh4ccd ? 32'sh0 : q;
	endfunction
	task automatic print_verdict();
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] x, y);
		checks_done++;
		if (y !== x)
		begin
			failures++;
			$display("Error %s expected %h seen %h", n, x, y);
		end
	endtask
	// register cycles; strobes rise and fall right after an edge
	task automatic wr(input logic [4:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wr_data <= d;
		wr_en <= 1'b1;
		@(posedge clk);
		wr_en <= 1'b0;
	endtask
	task automatic rd(input logic [4:0] a, output logic [31:0] d);
		@(posedge clk);
		addr <= a;
		rd_en <= 1'b1;
		@(posedge clk);
		rd_en <= 1'b0;
		@(negedge clk);
		d = rd_data;
	endtask
	// bounded wait for a commit
	task automatic samp();
		int n = 0;
		@(negedge clk);
		while (sample_done !== 1'b1 && n < 1000)
		begin
			@(negedge clk);
			n++;
		end
		if (n == 1000)
		begin
			failures++;
			print_verdict();
		end
	endtask
	// one auto or cascade sample; output and bias compared
	task automatic run(input logic [31:0] m, input logic signed [31:0] sv, pv, gn, bi);
		logic signed [31:0] q, x, o;
		wr(5'h00, m);
		wr(5'h01, m[1] ? 32'h0 : sv);
		wr(5'h02, gn);
		wr(5'h09, bi);
		pv_req <= pv;
		cas_req <= sv;
		samp();
		q = mulq(gn, errq(sv - pv, m));
		q = m[3] ? -q : q;
		x = q + bi;
		o = clampq(x);
		chk("control_out", o, control_out);
		rd(5'h09, c);
		chk("bias", m[5] || x == o ? bi : o - q, c);
	endtask
	initial
	begin
		repeat (20) @(posedge clk);
		arst_n <= 1'b1;
		repeat (3) @(posedge clk);
		// limits, rate, hysteresis; manual mode with every alarm on
		for (i = 0; i < 8; i++)
			wr(5'h0a + 5'(i), lm[i]);
		wr(5'h12, 32'h4ccd);
		wr(5'h00, 32'h3f800);
		wr(5'h08, 32'h6000);
		wr(5'h01, 32'h8000);
		pv_req <= 32'h8000;
		samp();
		samp();
		for (i = 1; i < 8; i++)
		begin
			@(posedge clk);
			pv_req <= pt[i];
			samp();
			chk("alarm_flags", {25'h0, ft[i]}, {25'h0, alarm_flags});
			chk("manual out", 32'h6000, control_out);
		end
		rd(5'h14, c);
		chk("status", {23'h0, ft[7], 2'h0}, c & 32'h3ff);
		$display("test alarms done");
		// bumpless switch, type one then type two
		wr(5'h02, 32'h10000);
		wr(5'h00, 32'h1);
		samp();
		chk("xfer out", 32'h6000, control_out);
		rd(5'h01, c);
		chk("xfer sp", pt[7], c);
		wr(5'h00, 32'h400);
		wr(5'h01, 32'h8000);
		samp();
		wr(5'h00, 32'h401);
		samp();
		chk("xfer2 out", 32'he000 - pt[7], control_out);
		$display("test transfer done");
		// random runs: auto or cascade, direct or reverse, freeze or adjust
		for (i = 0; i < 12; i++)
		begin
			s = $random(seed) & 32'hffff;
			v = $random(seed) & 32'hffff;
			g = (($random(seed) & 3) + 1) << 16;
			b = $random(seed) & 32'hffff;
			run(($random(seed) & 32'h28) | 32'(1 + i % 2), s, v, g, b);
		end
		// squared, deadband, both
		for (i = 0; i < 6; i++)
			run(32'h1 | 32'((i / 2 + 1) << 7), 32'sh8000 + et[i], 32'sh8000, 32'sh10000, 32'sh8000);
		$display("test position done");
		// setpoint step rescales bias: direct, reverse, clamped
		for (i = 0; i < 3; i++)
		begin
			b = i == 2 ? 32'shc000 : 32'sh4000;
			run(32'h11 | 32'((i % 2) << 3), 32'sh8000, 32'sh8000, 32'sh0, 32'sh0);
			wr(5'h09, b);
			wr(5'h01, 32'h10000);
			samp();
			chk("step out", clampq(i == 1 ? b >>> 1 : b <<< 1), control_out);
		end
		$display("test step done");
		// root of exact squares
		for (i = 0; i < 3; i++)
		begin
			v = $random(seed) & 32'hff;
			wr(5'h00, 32'h41);
			pv_req <= v * v;
			samp();
			rd(5'h15, c);
			chk("pv root", v << 8, c);
		end
		$display("test root done");
		print_verdict();
	end
endmodule
